// ### inc/wdmfr_map.vh
// Purpose: Register map, field positions and reset values of the watchdog
// Assumes: 32-bit peripheral bus with byte addresses
// Notes:   Definitions only; included by bare name
`ifndef WDMFR_MAP_VH
`define WDMFR_MAP_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define WDMFR_ADDR_MODE 32'h40004000
`define WDMFR_ADDR_RELOAD 32'h40004004
`define WDMFR_ADDR_FEED 32'h40004008
`define WDMFR_ADDR_VALUE 32'h4000400c

// ----------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------
`define WDMFR_BIT_RUN 0
`define WDMFR_BIT_RST 1
`define WDMFR_BIT_TOF 2
`define WDMFR_BIT_IRQ 3

// ----------------------------------------------------------------------
// Widths, reset values and feed codes
// ----------------------------------------------------------------------
`define WDMFR_CNT_W 24
`define WDMFR_CNT_MSB 23
`define WDMFR_RELOAD_FLOOR 24'h0000ff
`define WDMFR_RELOAD_RESET 24'h0000ff
`define WDMFR_FEED_FIRST 8'haa
`define WDMFR_FEED_SECOND 8'h55
`define WDMFR_PRESCALE_LAST 2'h3
`define WDMFR_CNT_ZERO 24'h000000
`define WDMFR_CNT_ONE 24'h000001

`endif

// ### rtl/wdmfr_counter.v
// Purpose: Count clock sampling, divide-by-4 prescaler, 24-bit down counter
// Assumes: count_clock_in slower than half of clk_in
// Notes:   Underflow is a one-cycle pulse when the counter leaves zero
`timescale 1ns/1ps
`include "wdmfr_map.vh"

module wdmfr_counter (
  input wire clk_in,
  input wire reset_in,
  input wire count_clock_in,
  input wire run_in,
  input wire load_in,
  input wire [23:0] load_value_in,
  output reg [23:0] count_out,
  output reg underflow_out
);

  reg [1:0] clk_sync;
  reg clk_prev;
  reg [1:0] prescale;
  wire [1:0] sync_chain;
  wire count_edge;
  wire tick;
  genvar i;

  // ----------------------------------------------------------------------
  // Two-flop synchroniser for the count clock pin
  // ----------------------------------------------------------------------

  // Stage i takes chain bit i, so no stage ever indexes below zero
  assign sync_chain = {clk_sync[0], count_clock_in};

  generate
    for (i = 0; i < 2; i = i + 1) begin : g_sync
      always @(posedge clk_in) begin
        if (reset_in) begin
          clk_sync[i] <= 1'b0;
        end else begin
          clk_sync[i] <= sync_chain[i];
        end
      end
    end
  endgenerate

  // Edge detect on the second stage only, never on the first
  always @(posedge clk_in) begin
    if (reset_in) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_sync[1];
    end
  end

  assign count_edge = clk_sync[1] & ~clk_prev;
  assign tick = count_edge & (prescale == `WDMFR_PRESCALE_LAST);

  // Fixed divide-by-4 prescaler, restarted on each reload
  always @(posedge clk_in) begin
    if (reset_in || load_in || !run_in) begin
      prescale <= 2'h0;
    end else if (count_edge) begin
      prescale <= prescale + 2'h1;
    end
  end

  // Down counter; a load beats a tick in the same cycle
  always @(posedge clk_in) begin
    if (reset_in) begin
      count_out <= `WDMFR_RELOAD_RESET;
      underflow_out <= 1'b0;
    end else if (load_in) begin
      count_out <= load_value_in;
      underflow_out <= 1'b0;
    end else if (run_in && tick) begin
      count_out <= count_out - `WDMFR_CNT_ONE;
      underflow_out <= (count_out == `WDMFR_CNT_ZERO);
    end else begin
      underflow_out <= 1'b0;
    end
  end

endmodule

// ### rtl/wdmfr_top.v
// Purpose: Watchdog with mode, reload constant, feed and value registers
// Assumes: APB slave on clk_in; count clock arrives as a pin and is sampled
// Notes:   Reset cause input lets the timeout flag survive its own reset
`timescale 1ns/1ps
`include "wdmfr_map.vh"

module wdmfr_top (
  input wire clk_in,
  input wire reset_in,
  input wire wd_reset_cause_in,
  input wire count_clock_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [31:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  output reg irq_out,
  output reg chip_reset_out,
  output reg clock_source_lock_out
);

  // ----------------------------------------------------------------------
  // Feed tracker states
  // ----------------------------------------------------------------------
  localparam FEED_IDLE = 1'b0;
  localparam FEED_GOT_FIRST = 1'b1;

  // Software-visible shadow of the set-only enables
  reg shadow_run;
  reg shadow_rst;
  // Enables in force, copied from the shadow on each feed
  reg active_run;
  reg active_rst;
  reg started;
  reg timeout_flag;
  reg timeout_irq_flag;
  reg [23:0] reload_constant;
  reg feed_state;
  reg next_feed_state;
  reg feed_done;
  reg feed_error;
  wire [23:0] count_value;
  wire underflow;
  wire setup_phase;
  wire access_phase;
  wire wr_access;
  wire [7:0] feed_byte;
  wire timeout_event;
  wire [23:0] reload_written;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------

  // Address match against one register, used by every decode below
  function addr_hit;
    input [31:0] addr;
    input [31:0] reg_addr;
    begin
      addr_hit = (addr == reg_addr);
    end
  endfunction

  // True when the address belongs to any watchdog register
  function any_hit;
    input [31:0] addr;
    begin
      any_hit = addr_hit(addr, `WDMFR_ADDR_MODE) ||
                addr_hit(addr, `WDMFR_ADDR_RELOAD) ||
                addr_hit(addr, `WDMFR_ADDR_FEED) ||
                addr_hit(addr, `WDMFR_ADDR_VALUE);
    end
  endfunction

  assign setup_phase = psel_in & ~penable_in;
  assign access_phase = psel_in & penable_in;
  assign wr_access = access_phase & pwrite_in;
  assign feed_byte = pwdata_in[7:0];

  // Floor the written reload value so the shortest interval is 256 ticks
  assign reload_written =
    (pwdata_in[`WDMFR_CNT_MSB:0] < `WDMFR_RELOAD_FLOOR) ?
    `WDMFR_RELOAD_FLOOR : pwdata_in[`WDMFR_CNT_MSB:0];

  // ----------------------------------------------------------------------
  // Feed sequence tracker
  // ----------------------------------------------------------------------

  // Classify each access phase: completion, error, or neither
  always @* begin
    next_feed_state = feed_state;
    feed_done = 1'b0;
    feed_error = 1'b0;
    case (feed_state)
      FEED_IDLE: begin
        if (wr_access && addr_hit(paddr_in, `WDMFR_ADDR_FEED) &&
            feed_byte == `WDMFR_FEED_FIRST) begin
          next_feed_state = FEED_GOT_FIRST;
        end
      end
      FEED_GOT_FIRST: begin
        if (wr_access && addr_hit(paddr_in, `WDMFR_ADDR_FEED) &&
            feed_byte == `WDMFR_FEED_SECOND) begin
          feed_done = 1'b1;
          next_feed_state = FEED_IDLE;
        end else if (access_phase && any_hit(paddr_in)) begin
          feed_error = 1'b1;
          next_feed_state = FEED_IDLE;
        end
      end
      default: begin
        next_feed_state = FEED_IDLE;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (reset_in) begin
      feed_state <= FEED_IDLE;
    end else begin
      feed_state <= next_feed_state;
    end
  end

  // ----------------------------------------------------------------------
  // Timeout events
  // ----------------------------------------------------------------------

  // Feed errors count only once a valid feed has started the watchdog
  assign timeout_event = (underflow && active_run && started) ||
                         (feed_error && active_run && started);

  // ----------------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------------

  // Set-only shadow bits; a zero write leaves them alone
  always @(posedge clk_in) begin
    if (reset_in || timeout_event) begin
      shadow_run <= 1'b0;
      shadow_rst <= 1'b0;
    end else if (wr_access && addr_hit(paddr_in, `WDMFR_ADDR_MODE)) begin
      shadow_run <= shadow_run | pwdata_in[`WDMFR_BIT_RUN];
      shadow_rst <= shadow_rst | pwdata_in[`WDMFR_BIT_RST];
    end
  end

  // Enables in force load only on a completed feed; a timeout clears them
  always @(posedge clk_in) begin
    if (reset_in || timeout_event) begin
      active_run <= 1'b0;
      active_rst <= 1'b0;
      started <= 1'b0;
    end else if (feed_done) begin
      active_run <= shadow_run;
      active_rst <= shadow_rst;
      started <= shadow_run;
    end
  end

  // Timeout flag survives only the watchdog's own reset; set beats clear
  always @(posedge clk_in) begin
    if (reset_in && !wd_reset_cause_in) begin
      timeout_flag <= 1'b0;
    end else if (reset_in) begin
      timeout_flag <= timeout_flag;
    end else if (timeout_event) begin
      timeout_flag <= 1'b1;
    end else if (wr_access && addr_hit(paddr_in, `WDMFR_ADDR_MODE) &&
                 !pwdata_in[`WDMFR_BIT_TOF]) begin
      timeout_flag <= 1'b0;
    end
  end

  // Interrupt flag: no software clear path at all
  always @(posedge clk_in) begin
    if (reset_in) begin
      timeout_irq_flag <= 1'b0;
    end else if (timeout_event) begin
      timeout_irq_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Reload constant register
  // ----------------------------------------------------------------------
  always @(posedge clk_in) begin
    if (reset_in) begin
      reload_constant <= `WDMFR_RELOAD_RESET;
    end else if (wr_access && addr_hit(paddr_in, `WDMFR_ADDR_RELOAD)) begin
      reload_constant <= reload_written;
    end
  end

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------

  // Counting sits on the bus clock, so updates reach it at once
  wdmfr_counter u_counter (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .count_clock_in(count_clock_in),
    .run_in(active_run & started),
    .load_in(feed_done),
    .load_value_in(reload_constant),
    .count_out(count_value),
    .underflow_out(underflow)
  );

  // ----------------------------------------------------------------------
  // Outputs to the system
  // ----------------------------------------------------------------------

  // Chip reset holds until the system reset comes back around
  always @(posedge clk_in) begin
    if (reset_in) begin
      chip_reset_out <= 1'b0;
    end else if (timeout_event && active_rst) begin
      chip_reset_out <= 1'b1;
    end
  end

  // Level request; the interrupt controller masks it, never this block
  always @(posedge clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= timeout_irq_flag;
    end
  end

  // Lock follows the software-visible enable, so it holds before a feed
  always @(posedge clk_in) begin
    if (reset_in) begin
      clock_source_lock_out <= 1'b0;
    end else begin
      clock_source_lock_out <= shadow_run | active_run;
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------

  // Zero wait states; ready low only in the first cycle after reset
  always @(posedge clk_in) begin
    if (reset_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= 1'b1;
    end
  end

  // Read data and error captured in setup phase, shown in access phase
  always @(posedge clk_in) begin
    if (reset_in) begin
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
    end else if (setup_phase) begin
      prdata_out <= 32'h00000000;
      pslverr_out <= ~any_hit(paddr_in);
      if (pwrite_in) begin
        prdata_out <= 32'h00000000;
      end else if (addr_hit(paddr_in, `WDMFR_ADDR_MODE)) begin
        prdata_out[`WDMFR_BIT_RUN] <= shadow_run;
        prdata_out[`WDMFR_BIT_RST] <= shadow_rst;
        prdata_out[`WDMFR_BIT_TOF] <= timeout_flag;
        prdata_out[`WDMFR_BIT_IRQ] <= timeout_irq_flag;
      end else if (addr_hit(paddr_in, `WDMFR_ADDR_RELOAD)) begin
        prdata_out[`WDMFR_CNT_MSB:0] <= reload_constant;
      end else if (addr_hit(paddr_in, `WDMFR_ADDR_VALUE)) begin
        prdata_out[`WDMFR_CNT_MSB:0] <= count_value;
      end
    end else if (!psel_in) begin
      pslverr_out <= 1'b0;
    end
  end

endmodule

// ### tb/wdmfr_cpu_model.sv
// Purpose: Processor side of the watchdog: bus master and count clock
// Assumes: Ready sampled on rising edges, drive 1 ns after each edge
// Notes:   Released address and data lines carry inverted junk
`timescale 1ns/1ps
`include "wdmfr_map.vh"

module wdmfr_cpu_model (
  input wire clk_in,
  input wire [31:0] prdata_in,
  input wire pready_in,
  input wire pslverr_in,
  output reg psel_out,
  output reg penable_out,
  output reg pwrite_out,
  output reg [31:0] paddr_out,
  output reg [31:0] pwdata_out,
  output reg count_clock_out,
  output reg err_out
);
  reg [31:0] junk;

  // Free count clock, phase unrelated to the bus clock
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 32'h0;
    pwdata_out = 32'h0;
    err_out = 1'b0;
    count_clock_out = 1'b0;
    #3;
    forever #21 count_clock_out = ~count_clock_out;
  end

  // ----------------------------------------
  // One bus transfer, held until ready
  // ----------------------------------------
  task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] q);
    integer n;
    begin
      @(posedge clk_in);
      #1;
      psel_out = 1'b1;
      pwrite_out = w;
      paddr_out = a;
      pwdata_out = d;
      @(posedge clk_in);
      #1;
      penable_out = 1'b1;
      n = 0;
      @(posedge clk_in);
      while (pready_in !== 1'b1 && n < 16) begin
        @(posedge clk_in);
        n = n + 1;
      end
      if (pready_in !== 1'b1) begin
        test_watchdog_mode_feed_reload.mismatches =
          test_watchdog_mode_feed_reload.mismatches + 1;
        test_watchdog_mode_feed_reload.complete_run;
      end
      q = prdata_in;
      err_out = pslverr_in;
      #1;
      psel_out = 1'b0;
      penable_out = 1'b0;
      paddr_out = ~a;
      pwdata_out = ~d;
    end
  endtask

  task wr(input [31:0] a, input [31:0] d);
    xfer(1'b1, a, d, junk);
  endtask

  task rd(input [31:0] a, output [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask

  // Reserved mode bits always written as zero
  task wr_mode(input [31:0] d);
    wr(`WDMFR_ADDR_MODE, d & 32'hf);
  endtask

  // Both feed writes back to back, nothing may slip between
  task feed;
    begin
      wr(`WDMFR_ADDR_FEED, 32'haa);
      wr(`WDMFR_ADDR_FEED, 32'h55);
    end
  endtask
endmodule

// ### tb/wdmfr_properties.sv
// Purpose: Port-level checks of the watchdog
// Assumes: Single bus clock, synchronous active-high reset
// Notes:   Feed state and enables tracked here from bus traffic
`timescale 1ns/1ps
`include "wdmfr_map.vh"

module wdmfr_properties (
  input wire clk_in,
  input wire reset_in,
  input wire wd_reset_cause_in,
  input wire count_clock_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [31:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire irq_out,
  input wire chip_reset_out,
  input wire clock_source_lock_out
);
  reg wait55, sh_run, sh_rst, on_run, on_rst;
  wire acc = psel_in && penable_in && pready_out;
  wire hit = acc && ((paddr_in & ~32'hc) == `WDMFR_ADDR_MODE);
  wire wr_md = acc && pwrite_in && paddr_in == `WDMFR_ADDR_MODE;
  wire wr_run = wr_md && pwdata_in[0];
  wire wr_fd = acc && pwrite_in && paddr_in == `WDMFR_ADDR_FEED;
  wire fd55 = wr_fd && pwdata_in[7:0] == 8'h55;
  wire fd_err = wait55 && hit && !fd55;
  wire rd_rl = acc && !pwrite_in && paddr_in == `WDMFR_ADDR_RELOAD;

  // Enables dropped once irq shows, so a dead dog never looks armed
  always @(posedge clk_in) begin
    if (reset_in) begin
      wait55 <= 1'b0;
    end else begin
      wait55 <= wait55 ? !hit : (wr_fd && pwdata_in[7:0] == 8'haa);
    end
    if (reset_in || irq_out) begin
      sh_run <= 1'b0;
      sh_rst <= 1'b0;
      on_run <= 1'b0;
      on_rst <= 1'b0;
    end else begin
      sh_run <= sh_run | wr_run;
      sh_rst <= sh_rst | (wr_md & pwdata_in[1]);
      if (wait55 && fd55) begin
        on_run <= sh_run;
        on_rst <= sh_rst;
      end
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (reset_in);

  chk_irq_cleared:
    assert property ($fell(reset_in) |-> !irq_out && !chip_reset_out)
    else $error("irq or chip reset left set by reset");
  chk_irq_held:
    assert property (irq_out |=> irq_out)
    else $error("irq dropped without reset");
  chk_reset_held:
    assert property (chip_reset_out |=> chip_reset_out)
    else $error("chip reset dropped");
  chk_lock_cause:
    assert property ($rose(clock_source_lock_out) |->
      $past(wr_run) || $past(wr_run, 2))
    else $error("lock rose without run write");
  chk_err_reset:
    assert property (fd_err && on_run && on_rst |-> ##[1:2] chip_reset_out)
    else $error("no chip reset after feed error");
  chk_err_irq:
    assert property (fd_err && on_run |-> ##[1:3] irq_out)
    else $error("no irq after feed error");
  chk_err_ignored:
    assert property (fd_err && !on_run && !irq_out |=> !irq_out [*3])
    else $error("feed error acted before first feed");
  chk_idle_quiet:
    assert property (!on_run && !irq_out |=> !irq_out && !chip_reset_out)
    else $error("timeout while not running");
  chk_zero_keeps:
    assert property (wr_md && clock_source_lock_out |=>
      clock_source_lock_out || irq_out)
    else $error("run enable cleared by write");
  chk_reload_floor:
    assert property (rd_rl |-> prdata_out[31:24] == 8'h00 &&
      prdata_out[23:0] >= 24'hff)
    else $error("reload below floor");

  cov_feed: cover property (wait55 && fd55 && sh_run);
  cov_irq: cover property ($rose(irq_out) && !chip_reset_out);
  cov_err_rst: cover property (fd_err && on_rst);
endmodule

bind wdmfr_top wdmfr_properties u_props (.clk_in(clk_in),
  .reset_in(reset_in), .wd_reset_cause_in(wd_reset_cause_in),
  .count_clock_in(count_clock_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out),
  .chip_reset_out(chip_reset_out),
  .clock_source_lock_out(clock_source_lock_out));

// ### tb/test_watchdog_mode_feed_reload.sv
// Purpose: Self-checking bench of the watchdog
// Assumes: Count clock from the processor model, 21 bus clocks a tick
// Notes:   Underflow waited in real time, so reload is kept small
`timescale 1ns/1ps
`include "wdmfr_map.vh"
`define CHK(g, e) begin \
  checked = checked + 1; \
  if ((g) !== (e)) begin \
    mismatches = mismatches + 1; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module test_watchdog_mode_feed_reload;
  reg clk_in, reset_in, cause;
  wire cclk, psel, pen, pwr, rdy, serr, irq, crst, lock, err;
  wire [31:0] addr, wdat, rdat;
  integer mismatches, checked, i;
  reg [31:0] rd, rl, tv;

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  wdmfr_cpu_model cpu (.clk_in(clk_in), .prdata_in(rdat), .pready_in(rdy),
    .pslverr_in(serr), .psel_out(psel), .penable_out(pen),
    .pwrite_out(pwr), .paddr_out(addr), .pwdata_out(wdat),
    .count_clock_out(cclk), .err_out(err));
  wdmfr_top dut (.clk_in(clk_in), .reset_in(reset_in),
    .wd_reset_cause_in(cause), .count_clock_in(cclk), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdat),
    .prdata_out(rdat), .pready_out(rdy), .pslverr_out(serr),
    .irq_out(irq), .chip_reset_out(crst), .clock_source_lock_out(lock));

  task complete_run;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask

  task cyc(input integer k);
    begin
      repeat (k) @(posedge clk_in);
      #1;
    end
  endtask

  // Three cycles of reset, cause marks a reset from the watchdog
  task do_reset(input c);
    begin
      @(posedge clk_in);
      #1;
      reset_in = 1'b1;
      cause = c;
      cyc(3);
      reset_in = 1'b0;
      cause = 1'b0;
      cyc(2);
    end
  endtask

  // Bounded wait for irq (sel 0) or chip reset (sel 1)
  task wait_hi(input integer sel, input integer lim);
    integer n;
    begin
      n = 0;
      while ((sel ? crst : irq) !== 1'b1 && n < lim) begin
        cyc(1);
        n = n + 1;
      end
      if (n >= lim) begin
        mismatches = mismatches + 1;
        complete_run;
      end
    end
  endtask

  function [31:0] exp_reload(input [31:0] w);
    exp_reload = (w[23:0] < 24'hff) ? 32'hff : {8'h00, w[23:0]};
  endfunction

  function [3:0] exp_mode(input r, input e, input t, input q);
    exp_mode = {q, t, e, r};
  endfunction

  initial begin
    reset_in = 1'b1;
    cause = 1'b0;
    mismatches = 0;
    checked = 0;
    void'($urandom(48622));
    cyc(3);
    reset_in = 1'b0;
    cyc(2);
    // Reset values, reload floor, read-only value, unmapped place
    cpu.rd(`WDMFR_ADDR_MODE, rd);
    `CHK(rd[3:0], exp_mode(1'b0, 1'b0, 1'b0, 1'b0))
    cpu.wr(`WDMFR_ADDR_VALUE, 32'h1234);
    cpu.rd(`WDMFR_ADDR_VALUE, rd);
    `CHK(rd, 32'hff)
    cpu.rd(`WDMFR_ADDR_RELOAD, rd);
    `CHK(rd, 32'hff)
    for (i = 0; i < 8; i = i + 1) begin
      case (i)
        0: tv = 32'h0;
        1: tv = 32'hfe;
        2: tv = 32'hff;
        3: tv = 32'h100;
        4: tv = 32'hffffffff;
        default: tv = (i == 5) ? $urandom % 512 : $urandom;
      endcase
      cpu.wr(`WDMFR_ADDR_RELOAD, tv);
      cpu.rd(`WDMFR_ADDR_RELOAD, rd);
      `CHK(rd, exp_reload(tv))
    end
    cpu.rd(32'h40004010, rd);
    `CHK({err, rd}, 33'h100000000)
    $display("test reset_map done");
    // Run set without feed: no load, no count, errors ignored
    rl = 32'h100 + ($urandom % 32'h80);
    cpu.wr(`WDMFR_ADDR_RELOAD, rl);
    cpu.wr_mode(32'h1);
    cyc(2);
    `CHK(lock, 1'b1)
    cyc(120);
    cpu.rd(`WDMFR_ADDR_VALUE, rd);
    `CHK(rd, 32'hff)
    cpu.wr(`WDMFR_ADDR_FEED, 32'haa);
    cpu.rd(`WDMFR_ADDR_RELOAD, rd);
    cyc(4);
    `CHK({irq, crst}, 2'b00)
    $display("test no_feed done");
    // Feed loads and starts, zero write keeps run
    cpu.feed;
    cpu.rd(`WDMFR_ADDR_VALUE, rd);
    `CHK(rd, rl)
    cyc(105);
    cpu.rd(`WDMFR_ADDR_VALUE, rd);
    `CHK(rl - rd >= 4 && rl - rd <= 6, 1'b1)
    cpu.wr_mode(32'h0);
    cpu.rd(`WDMFR_ADDR_MODE, rd);
    `CHK(rd[0], 1'b1)
    cpu.feed;
    cpu.rd(`WDMFR_ADDR_VALUE, rd);
    `CHK(rd, rl)
    $display("test feed done");
    // Underflow in interrupt mode
    wait_hi(0, 10000);
    cpu.rd(`WDMFR_ADDR_MODE, rd);
    `CHK({crst, rd[3:0]}, {1'b0, exp_mode(1'b0, 1'b0, 1'b1, 1'b1)})
    `CHK(lock, 1'b0)
    cpu.wr_mode(32'h0);
    cpu.rd(`WDMFR_ADDR_MODE, rd);
    `CHK(rd[2], 1'b0)
    `CHK(rd[3], 1'b1)
    `CHK(irq, 1'b1)
    $display("test underflow done");
    // Reset mode: broken feed resets the chip, flag survives
    do_reset(1'b0);
    `CHK(irq, 1'b0)
    cpu.wr_mode(32'h3);
    cpu.feed;
    cpu.wr(`WDMFR_ADDR_FEED, 32'haa);
    cpu.rd(`WDMFR_ADDR_MODE, rd);
    wait_hi(1, 2);
    cyc(3);
    `CHK(crst, 1'b1)
    do_reset(1'b1);
    cpu.rd(`WDMFR_ADDR_MODE, rd);
    `CHK(rd[3:0], exp_mode(1'b0, 1'b0, 1'b1, 1'b0))
    do_reset(1'b0);
    cpu.rd(`WDMFR_ADDR_MODE, rd);
    `CHK(rd[2], 1'b0)
    // Reset mode underflow at the floored, shortest interval
    cpu.wr(`WDMFR_ADDR_RELOAD, 32'h0);
    cpu.wr_mode(32'h3);
    cpu.feed;
    wait_hi(1, 8000);
    `CHK(crst, 1'b1)
    $display("test feed_error done");
    complete_run;
  end
endmodule
